// ==== core/mfs_pkg.sv ====
// Constants shared by the mains fluctuation step sequencer.
// Assumes a single 250 MHz clock and a plain address/strobe register port.
package mfs_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_NS = 10_000_000;
    localparam int unsigned TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Field widths and limits
    // ----------------------------------------------------------------
    localparam int NUM_STEPS = 6;
    localparam int TW = 17;
    localparam int VW = 13;
    localparam int FW = 17;
    localparam int AW = 9;
    localparam int RW = 14;
    localparam logic [TW-1:0] TIME_MAX = 17'h1869f;
    localparam logic [RW-1:0] REPEAT_MAX = 14'h270f;
    localparam logic [AW-1:0] ANGLE_MAX = 9'h167;
    localparam logic [VW-1:0] VMAX_LOW = 13'h060e;
    localparam logic [VW-1:0] VMAX_MID = 13'h0c1c;
    localparam logic [VW-1:0] VMAX_HIGH = 13'h1770;
    localparam logic [FW-1:0] FMIN = 17'h01194;
    localparam logic [FW-1:0] FMAX_STD = 17'h0c350;
    localparam logic [FW-1:0] FMAX_OPT = 17'h186a0;

    // ----------------------------------------------------------------
    // Steps and voltage ranges
    // ----------------------------------------------------------------
    localparam logic [2:0] STEP_IDLE = 3'h0;
    localparam logic [2:0] STEP_PRE = 3'h1;
    localparam logic [2:0] STEP_RAMP_IN = 3'h2;
    localparam logic [2:0] STEP_FAULT = 3'h3;
    localparam logic [2:0] STEP_RAMP_OUT = 3'h4;
    localparam logic [2:0] STEP_POST = 3'h5;
    localparam logic [1:0] RANGE_LOW = 2'h0;
    localparam logic [1:0] RANGE_MID = 2'h1;
    localparam logic [1:0] RANGE_HIGH = 2'h2;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_REPEAT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_STEP_BASE = 8'h10;
    localparam logic [7:0] REG_STEP_END = 8'h70;
    localparam logic [1:0] FLD_TIME = 2'h0;
    localparam logic [1:0] FLD_PHASE = 2'h1;
    localparam logic [1:0] FLD_VSET = 2'h2;
    localparam logic [1:0] FLD_FSET = 2'h3;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CLR_REJ = 2;
    localparam int CTRL_RANGE_LSB = 4;
    localparam int PH_ON_EN = 0;
    localparam int PH_OFF_EN = 1;
    localparam int PH_TRIG = 2;
    localparam int PH_ON_LSB = 4;
    localparam int PH_OFF_LSB = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [TW-1:0] TIME_RST = 17'h00064;
    localparam logic [VW-1:0] VSET_RST = 13'h0000;
    localparam logic [FW-1:0] FSET_RST = 17'h01388;
    localparam logic [RW-1:0] REPEAT_RST = 14'h0001;
    localparam logic [1:0] RANGE_RST = 2'h1;

endpackage

// ==== core/mfs_ramp.sv ====
// Linear interpolator for one setpoint across a ramp step.
// Assumes tick pulses at the duration unit rate, widely spaced.
module mfs_ramp #(
    parameter int W = 13,
    parameter int DW = 17
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic tick,
    input wire logic [W-1:0] from_val,
    input wire logic [W-1:0] to_val,
    input wire logic [DW-1:0] dur,
    output logic [W-1:0] value
);

    localparam int ACW = DW + W + 1;

    logic [W-1:0] val_r;
    logic [W-1:0] to_r;
    logic [W-1:0] span_r;
    logic up_r;
    logic [DW-1:0] dur_r;
    logic [ACW-1:0] acc_r;
    logic [W-1:0] diff;
    logic up;
    logic owe;

    assign up = (to_val >= from_val);
    assign diff = up ? to_val - from_val : from_val - to_val;
    // Whole span added per tick, one duration paid per unit step: a fixed slope
    assign owe = (acc_r >= ACW'(dur_r)) && (val_r != to_r) && (dur_r != '0);
    assign value = val_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            val_r <= '0;
            to_r <= '0;
            dur_r <= '0;
            acc_r <= '0;
        end else if (start) begin
            val_r <= from_val;
            to_r <= to_val;
            span_r <= diff;
            up_r <= up;
            dur_r <= dur;
            acc_r <= '0;
        end else if (tick) begin
            acc_r <= acc_r + ACW'(span_r);
        end else if (owe) begin
            acc_r <= acc_r - ACW'(dur_r);
            val_r <= up_r ? val_r + W'(1) : val_r - W'(1);
        end
    end

endmodule

// ==== core/mfs_seq.sv ====
// Mains fluctuation step sequencer: six timed steps with ramps and phase control.
// Assumes phase_deg comes from the output stage on the same clock.
// Summary of operation
// - Steps run idle, pre, ramp-in, fault, ramp-out, post.
// - Idle step supplies output before and after runs.
// - Ramps move setpoints linearly between neighbouring steps.
// - Zero-duration ramp step is skipped entirely.
// - Durations 0.01 to 999.99 s; zero ramps only.
// - Start phase wait adds to step duration.
// - Non-ramp step may start at chosen angle.
// - Non-ramp step may stop at chosen angle.
// - Ramp steps keep only duration and trigger level.
// - Trigger output set to step level at start.
// - Cycle repeats 1 to 9999 times, zero forever.
// - One repeat count shared by every step.
// - Whole run uses one selected voltage range.
// - Out-of-range voltage setpoint rejected, old value kept.
// - Frequency 45 to 500 Hz, 1000 Hz optional.
module mfs_seq #(
    parameter int unsigned TICK_CYC = mfs_pkg::TICK_CYC_DEF,
    parameter bit HIGH_OPT = 1'b0,
    parameter bit FREQ_OPT = 1'b0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [mfs_pkg::AW-1:0] phase_deg,
    output logic out_on,
    output logic [mfs_pkg::VW-1:0] vset_out,
    output logic [mfs_pkg::FW-1:0] fset_out,
    output logic trig_out,
    output logic [2:0] step_out,
    output logic running
);

    localparam int TW = mfs_pkg::TW;
    localparam int VW = mfs_pkg::VW;
    localparam int FW = mfs_pkg::FW;
    localparam int AW = mfs_pkg::AW;
    localparam int RW = mfs_pkg::RW;
    localparam int N = mfs_pkg::NUM_STEPS;

    generate
        if (TICK_CYC < 2 || TICK_CYC > 32'h7fffffff) begin : g_bad_tick
            $error("TICK_CYC out of range");
        end
    endgenerate

    typedef enum logic [2:0] {S_OFF, S_PHASE, S_TIME, S_HOLD, S_STOP} mfs_state_e;

    // ----------------------------------------------------------------
    // Step settings
    // ----------------------------------------------------------------
    logic [TW-1:0] time_r [N];
    logic [VW-1:0] vset_r [N];
    logic [FW-1:0] fset_r [N];
    logic [AW-1:0] on_ang_r [N];
    logic [AW-1:0] off_ang_r [N];
    logic [N-1:0] on_en_r;
    logic [N-1:0] off_en_r;
    logic [N-1:0] trig_r;
    logic [RW-1:0] repeat_r;
    logic [1:0] range_r;
    logic reject_r;

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    mfs_state_e state_r;
    logic [2:0] step_r;
    logic [31:0] div_r;
    logic [TW-1:0] elapsed_r;
    logic [RW-1:0] cycles_r;
    logic [31:0] rdata_r;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire in_step = (addr >= mfs_pkg::REG_STEP_BASE) && (addr < mfs_pkg::REG_STEP_END);
    wire [7:0] step_off = addr - mfs_pkg::REG_STEP_BASE;
    wire [2:0] wsel = step_off[6:4];
    wire [1:0] fld = addr[3:2];
    wire wsel_ramp = (wsel == mfs_pkg::STEP_RAMP_IN) || (wsel == mfs_pkg::STEP_RAMP_OUT);
    wire wr_ctrl = wr && (addr == mfs_pkg::REG_CTRL);
    wire wr_rep = wr && (addr == mfs_pkg::REG_REPEAT);
    wire wr_step = wr && in_step;
    wire cmd_run = wr_ctrl && wdata[mfs_pkg::CTRL_RUN];
    wire cmd_stop = wr_ctrl && wdata[mfs_pkg::CTRL_STOP] && !wdata[mfs_pkg::CTRL_RUN];
    wire cmd_clr = wr_ctrl && wdata[mfs_pkg::CTRL_CLR_REJ];
    wire [1:0] range_w = wdata[mfs_pkg::CTRL_RANGE_LSB+:2];
    wire range_ok = (range_w == mfs_pkg::RANGE_LOW) || (range_w == mfs_pkg::RANGE_MID)
        || ((range_w == mfs_pkg::RANGE_HIGH) && HIGH_OPT);
    wire busy = (state_r != S_OFF);

    // Setpoint validation
    wire [VW-1:0] vmax = (range_r == mfs_pkg::RANGE_LOW) ? mfs_pkg::VMAX_LOW :
        (range_r == mfs_pkg::RANGE_MID) ? mfs_pkg::VMAX_MID : mfs_pkg::VMAX_HIGH;
    wire [FW-1:0] fmax = FREQ_OPT ? mfs_pkg::FMAX_OPT : mfs_pkg::FMAX_STD;
    wire time_ok = (wdata <= 32'(mfs_pkg::TIME_MAX)) && ((wdata != '0) || wsel_ramp);
    wire v_ok = (wdata <= 32'(vmax));
    wire f_ok = (wdata >= 32'(mfs_pkg::FMIN)) && (wdata <= 32'(fmax));
    wire [AW-1:0] on_ang_w = wdata[mfs_pkg::PH_ON_LSB+:AW];
    wire [AW-1:0] off_ang_w = wdata[mfs_pkg::PH_OFF_LSB+:AW];
    wire ang_ok = (on_ang_w <= mfs_pkg::ANGLE_MAX) && (off_ang_w <= mfs_pkg::ANGLE_MAX);
    wire rep_ok = (wdata <= 32'(mfs_pkg::REPEAT_MAX));
    wire ph_full = !wsel_ramp;
    wire take_time = wr_step && (fld == mfs_pkg::FLD_TIME) && time_ok;
    wire take_ph = wr_step && (fld == mfs_pkg::FLD_PHASE);
    wire take_v = wr_step && (fld == mfs_pkg::FLD_VSET) && !wsel_ramp && v_ok;
    wire take_f = wr_step && (fld == mfs_pkg::FLD_FSET) && !wsel_ramp && f_ok;
    wire rej = (wr_step && (fld == mfs_pkg::FLD_TIME) && !time_ok)
        || (take_ph && ph_full && !ang_ok)
        || (wr_step && (fld == mfs_pkg::FLD_VSET) && !wsel_ramp && !v_ok)
        || (wr_step && (fld == mfs_pkg::FLD_FSET) && !wsel_ramp && !f_ok)
        || (wr_rep && !rep_ok)
        || (wr_ctrl && !busy && !range_ok);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < N; i++) begin
                time_r[i] <= mfs_pkg::TIME_RST;
                vset_r[i] <= mfs_pkg::VSET_RST;
                fset_r[i] <= mfs_pkg::FSET_RST;
                on_ang_r[i] <= '0;
                off_ang_r[i] <= '0;
            end
            on_en_r <= '0;
            off_en_r <= '0;
            trig_r <= '0;
            repeat_r <= mfs_pkg::REPEAT_RST;
            range_r <= mfs_pkg::RANGE_RST;
            reject_r <= 1'b0;
        end else begin
            if (take_time) time_r[wsel] <= wdata[TW-1:0];
            if (take_v) vset_r[wsel] <= wdata[VW-1:0];
            if (take_f) fset_r[wsel] <= wdata[FW-1:0];
            if (take_ph) trig_r[wsel] <= wdata[mfs_pkg::PH_TRIG];
            if (take_ph && ph_full && ang_ok) begin
                on_en_r[wsel] <= wdata[mfs_pkg::PH_ON_EN];
                off_en_r[wsel] <= wdata[mfs_pkg::PH_OFF_EN];
                on_ang_r[wsel] <= on_ang_w;
                off_ang_r[wsel] <= off_ang_w;
            end
            if (wr_rep && rep_ok) repeat_r <= wdata[RW-1:0];
            // Range locked while a run is active
            if (wr_ctrl && !busy && range_ok) range_r <= range_w;
            // A rejection in the same cycle as the clear survives
            if (rej) reject_r <= 1'b1;
            else if (cmd_clr) reject_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Step sequencing
    // ----------------------------------------------------------------
    wire tick = (div_r == TICK_CYC - 1);
    wire step_ramp = (step_r == mfs_pkg::STEP_RAMP_IN) || (step_r == mfs_pkg::STEP_RAMP_OUT);
    wire time_up = tick && (elapsed_r + TW'(1) >= time_r[step_r]);
    wire last_cycle = (repeat_r != '0) && (cycles_r + RW'(1) >= repeat_r);
    wire at_on = (phase_deg == on_ang_r[step_r]);
    wire at_off = (phase_deg == off_ang_r[step_r]);
    logic [2:0] nxt_step;
    logic enter;
    logic [2:0] enter_step;

    always_comb begin
        case (step_r)
            mfs_pkg::STEP_IDLE: nxt_step = mfs_pkg::STEP_PRE;
            mfs_pkg::STEP_PRE: nxt_step = (time_r[mfs_pkg::STEP_RAMP_IN] == '0) ?
                mfs_pkg::STEP_FAULT : mfs_pkg::STEP_RAMP_IN;
            mfs_pkg::STEP_RAMP_IN: nxt_step = mfs_pkg::STEP_FAULT;
            mfs_pkg::STEP_FAULT: nxt_step = (time_r[mfs_pkg::STEP_RAMP_OUT] == '0) ?
                mfs_pkg::STEP_POST : mfs_pkg::STEP_RAMP_OUT;
            mfs_pkg::STEP_RAMP_OUT: nxt_step = mfs_pkg::STEP_POST;
            default: nxt_step = last_cycle ? mfs_pkg::STEP_IDLE : mfs_pkg::STEP_PRE;
        endcase
    end

    assign enter = cmd_run || (state_r == S_TIME && time_up && !cmd_stop);
    assign enter_step = cmd_run ? mfs_pkg::STEP_IDLE : nxt_step;
    wire finish = !cmd_run && (step_r == mfs_pkg::STEP_POST) && last_cycle;
    wire enter_ramp = (enter_step == mfs_pkg::STEP_RAMP_IN)
        || (enter_step == mfs_pkg::STEP_RAMP_OUT);
    wire ramp_start = enter && enter_ramp;
    wire enter_wait = on_en_r[enter_step] && !enter_ramp;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= S_OFF;
            step_r <= mfs_pkg::STEP_IDLE;
            div_r <= '0;
            elapsed_r <= '0;
            cycles_r <= '0;
        end else if (enter) begin
            step_r <= enter_step;
            div_r <= '0;
            elapsed_r <= '0;
            if (cmd_run) cycles_r <= '0;
            else if (step_r == mfs_pkg::STEP_POST) cycles_r <= cycles_r + RW'(1);
            // Finished runs park in the idle step with the output kept on
            if (finish) state_r <= S_HOLD;
            else state_r <= enter_wait ? S_PHASE : S_TIME;
        end else begin
            case (state_r)
                S_PHASE: begin
                    if (cmd_stop) state_r <= S_STOP;
                    else if (at_on) state_r <= S_TIME;
                end
                S_TIME: begin
                    div_r <= tick ? '0 : div_r + 32'(1);
                    if (tick) elapsed_r <= elapsed_r + TW'(1);
                    if (cmd_stop) state_r <= S_STOP;
                end
                S_HOLD: begin
                    if (cmd_stop) state_r <= S_STOP;
                end
                S_STOP: begin
                    if (step_ramp || !off_en_r[step_r] || at_off) begin
                        state_r <= S_OFF;
                        step_r <= mfs_pkg::STEP_IDLE;
                    end
                end
                default: state_r <= S_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Ramp interpolation
    // ----------------------------------------------------------------
    wire ramp_out_sel = (enter_step == mfs_pkg::STEP_RAMP_OUT);
    wire [VW-1:0] v_from = ramp_out_sel ? vset_r[mfs_pkg::STEP_FAULT] : vset_r[mfs_pkg::STEP_PRE];
    wire [VW-1:0] v_to = ramp_out_sel ? vset_r[mfs_pkg::STEP_POST] : vset_r[mfs_pkg::STEP_FAULT];
    wire [FW-1:0] f_from = ramp_out_sel ? fset_r[mfs_pkg::STEP_FAULT] : fset_r[mfs_pkg::STEP_PRE];
    wire [FW-1:0] f_to = ramp_out_sel ? fset_r[mfs_pkg::STEP_POST] : fset_r[mfs_pkg::STEP_FAULT];
    wire ramp_tick = tick && (state_r == S_TIME) && step_ramp;
    logic [VW-1:0] v_ramp;
    logic [FW-1:0] f_ramp;

    mfs_ramp #(.W(VW), .DW(TW)) u_v_ramp (
        .clk(clk),
        .resetn(resetn),
        .start(ramp_start),
        .tick(ramp_tick),
        .from_val(v_from),
        .to_val(v_to),
        .dur(time_r[enter_step]),
        .value(v_ramp)
    );

    mfs_ramp #(.W(FW), .DW(TW)) u_f_ramp (
        .clk(clk),
        .resetn(resetn),
        .start(ramp_start),
        .tick(ramp_tick),
        .from_val(f_from),
        .to_val(f_to),
        .dur(time_r[enter_step]),
        .value(f_ramp)
    );

    // ----------------------------------------------------------------
    // Outputs to the power stage
    // ----------------------------------------------------------------
    wire live = (state_r == S_PHASE) || (state_r == S_TIME) || (state_r == S_HOLD);
    wire drive = live || (state_r == S_STOP);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            out_on <= 1'b0;
            vset_out <= '0;
            fset_out <= '0;
            trig_out <= 1'b0;
            step_out <= '0;
            running <= 1'b0;
        end else begin
            out_on <= (state_r == S_TIME) || (state_r == S_HOLD) || (state_r == S_STOP);
            vset_out <= (step_ramp && drive) ? v_ramp : vset_r[step_r];
            fset_out <= (step_ramp && drive) ? f_ramp : fset_r[step_r];
            trig_out <= drive ? trig_r[step_r] : trig_r[mfs_pkg::STEP_IDLE];
            step_out <= step_r;
            running <= (state_r == S_PHASE) || (state_r == S_TIME);
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    wire [2:0] rsel = step_off[6:4];
    wire rsel_ramp = (rsel == mfs_pkg::STEP_RAMP_IN) || (rsel == mfs_pkg::STEP_RAMP_OUT);
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (addr == mfs_pkg::REG_CTRL) begin
            rd_mux[mfs_pkg::CTRL_RANGE_LSB+:2] = range_r;
        end else if (addr == mfs_pkg::REG_REPEAT) begin
            rd_mux[RW-1:0] = repeat_r;
        end else if (addr == mfs_pkg::REG_STATUS) begin
            rd_mux = {2'h0, cycles_r, 8'h0, 3'(state_r), reject_r, step_r, running};
        end else if (in_step && fld == mfs_pkg::FLD_TIME) begin
            rd_mux[TW-1:0] = time_r[rsel];
        end else if (in_step && fld == mfs_pkg::FLD_PHASE) begin
            rd_mux[mfs_pkg::PH_TRIG] = trig_r[rsel];
            if (!rsel_ramp) begin
                rd_mux[mfs_pkg::PH_ON_EN] = on_en_r[rsel];
                rd_mux[mfs_pkg::PH_OFF_EN] = off_en_r[rsel];
                rd_mux[mfs_pkg::PH_ON_LSB+:AW] = on_ang_r[rsel];
                rd_mux[mfs_pkg::PH_OFF_LSB+:AW] = off_ang_r[rsel];
            end
        end else if (in_step && fld == mfs_pkg::FLD_VSET && !rsel_ramp) begin
            rd_mux[VW-1:0] = vset_r[rsel];
        end else if (in_step && fld == mfs_pkg::FLD_FSET && !rsel_ramp) begin
            rd_mux[FW-1:0] = fset_r[rsel];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) rdata_r <= '0;
        else if (rd) rdata_r <= rd_mux;
    end

    assign rdata = rdata_r;

endmodule

// ==== testbench/mfs_seq_properties.sv ====
// Port checker for the step sequencer.
// Assumes it is bound onto mfs_seq and sees its ports only.
module mfs_seq_properties #(
    parameter int unsigned TICK_CYC = 20,
    parameter bit HIGH_OPT = 1'b0,
    parameter bit FREQ_OPT = 1'b0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [mfs_pkg::AW-1:0] phase_deg,
    input wire logic out_on,
    input wire logic [mfs_pkg::VW-1:0] vset_out,
    input wire logic [mfs_pkg::FW-1:0] fset_out,
    input wire logic trig_out,
    input wire logic [2:0] step_out,
    input wire logic running
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_step_order: assert property ($changed(step_out) |-> step_out == 3'h0 ||
        step_out == $past(step_out) + 3'h1 || ($past(step_out) == 3'h5 && step_out == 3'h1) ||
        ($past(step_out[0]) && step_out == $past(step_out) + 3'h2))
        else $error("illegal step transition");
    chk_step_legal: assert property (step_out <= 3'h5)
        else $error("step out of range");
    chk_off_idle: assert property (!out_on && !running |-> step_out == 3'h0)
        else $error("off outside idle step");
    chk_ramp_on: assert property (step_out == 3'h2 || step_out == 3'h4 |-> out_on)
        else $error("ramp step waited on phase");
    chk_reset_quiet: assert property (disable iff (1'b0) !resetn |=>
        !out_on && !running && !trig_out && step_out == 3'h0) else $error("outputs live in reset");
    chk_trig_steady: assert property ($changed(trig_out) && running |-> $changed(step_out))
        else $error("trigger moved inside a step");
    chk_vset_cap: assert property (vset_out <= (HIGH_OPT ? mfs_pkg::VMAX_HIGH : mfs_pkg::VMAX_MID))
        else $error("voltage above range");
    chk_fset_band: assert property (out_on |-> fset_out >= mfs_pkg::FMIN &&
        fset_out <= (FREQ_OPT ? mfs_pkg::FMAX_OPT : mfs_pkg::FMAX_STD)) else $error("frequency outside band");
    cov_ramp: cover property (step_out == 3'h2);
    cov_skip: cover property ($past(step_out) == 3'h3 && step_out == 3'h5);
    cov_hold: cover property (out_on && !running);
endmodule

bind mfs_seq mfs_seq_properties #(.TICK_CYC(TICK_CYC), .HIGH_OPT(HIGH_OPT), .FREQ_OPT(FREQ_OPT))
    i_chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .phase_deg(phase_deg), .out_on(out_on), .vset_out(vset_out),
    .fset_out(fset_out), .trig_out(trig_out), .step_out(step_out), .running(running));

// ==== testbench/mfs_seq_tb.sv ====
// Self-checking bench for the step sequencer.
// Assumes the free running stage model drives phase_deg.
module mfs_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 20;
    logic clk = 1'b0, resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0, rd = 1'b0;
    logic [31:0] rdata, v;
    logic [mfs_pkg::AW-1:0] phase_deg;
    logic [mfs_pkg::VW-1:0] vset_out;
    logic [mfs_pkg::FW-1:0] fset_out;
    logic out_on, trig_out, running;
    logic [2:0] step_out, last;
    logic [16:0] q[$];
    int failures = 0, total_checks = 0, cyc = 0, cnt = 0, hic = 0, n5 = 0;
    bit rec = 0, ph = 0, sp = 0, on_q = 0;
    always #2 clk = ~clk;
    mfs_seq #(.TICK_CYC(TK)) i_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .phase_deg(phase_deg), .out_on(out_on),
        .vset_out(vset_out), .fset_out(fset_out), .trig_out(trig_out), .step_out(step_out),
        .running(running));
    mfs_stage i_stage (.clk(clk), .resetn(resetn), .phase_deg(phase_deg));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobe drops with a gap cycle so no signal is driven twice per step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        wr_reg(a, d);
        rd_reg(a);
        check($sformatf("reg %h", a), e, v);
    endtask
    // ----------------------------------------------------------------
    // Step monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            results();
        end
        if (step_out !== last) begin
            if (ph && last == 3'h1) check("on_time", 1, hic >= 2 * TK - 1 && hic <= 2 * TK + 3);
            if (step_out == 3'h5) n5++;
            cnt = 0;
            hic = 0;
            last = step_out;
        end
        cnt++;
        if (out_on && step_out == 3'h1) hic++;
        if (rec && cnt == 3 && step_out != 3'h2) q.push_back({step_out, trig_out, vset_out});
        if (rec && cnt == 30 && step_out == 3'h2) check("ramp_mid", 1, vset_out > 13'h3e8 && vset_out < 13'h406);
        if (ph && out_on && !on_q && step_out == 3'h1) check("on_phase", 1, phase_deg >= 9'h5a && phase_deg <= 9'h5d);
        if (sp && !out_on && on_q) check("off_phase", 1, phase_deg >= 9'hc8 && phase_deg <= 9'hcb);
        on_q = out_on;
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] tm[6] = '{32'h1, 32'h2, 32'h2, 32'h2, 32'h0, 32'h2};
        logic [16:0] e[7] = '{17'h63e8, 17'he406, 17'h141f4, 17'h63e8, 17'he406, 17'h141f4, 17'h0};
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_reg(8'h04);
        check("repeat", 32'h1, v);
        rd_reg(8'h00);
        check("range", 32'h10, v);
        rd_reg(8'h10);
        check("time", 32'h64, v);
        rd_reg(8'h2c);
        check("fset", 32'h1388, v);
        rd_reg(8'h80);
        check("unmapped", 32'h0, v);
        $display("test reset values done");
        wr_chk(8'h48, 32'hc1d, 32'h0);
        wr_chk(8'h48, 32'hc1c, 32'hc1c);
        rd_reg(8'h08);
        check("reject", 32'h10, v & 32'h10);
        wr_chk(8'h4c, 32'h1193, 32'h1388);
        wr_chk(8'h4c, 32'hc351, 32'h1388);
        wr_chk(8'h4c, 32'hc350, 32'hc350);
        wr_chk(8'h40, 32'h0, 32'h64);
        wr_chk(8'h40, 32'h186a0, 32'h64);
        wr_chk(8'h40, 32'h1869f, 32'h1869f);
        wr_chk(8'h30, 32'h0, 32'h0);
        wr_chk(8'h38, 32'h3e8, 32'h0);
        wr_chk(8'h44, 32'h1681, 32'h0);
        wr_chk(8'h04, 32'h2710, 32'h1);
        wr_chk(8'h00, 32'h20, 32'h10);
        wr_chk(8'h00, 32'h0, 32'h0);
        wr_chk(8'h48, 32'h60f, 32'hc1c);
        wr_chk(8'h48, 32'h60e, 32'h60e);
        wr_chk(8'h00, 32'h14, 32'h10);
        $display("test limits done");
        for (int s = 0; s < 6; s++) wr_reg(8'h10 + 8'(s * 16), tm[s]);
        wr_reg(8'h28, 32'h3e8);
        wr_reg(8'h48, 32'h406);
        wr_reg(8'h68, 32'h1f4);
        wr_reg(8'h24, 32'h4);
        wr_reg(8'h44, 32'h4);
        wr_reg(8'h04, 32'h2);
        rec = 1;
        wr_reg(8'h00, 32'h11);
        for (int i = 0; i < 3000 && q.size() < 7; i++) @(posedge clk);
        for (int i = 0; i < 7; i++) check("step", e[i], q[i]);
        check("hold", 1, out_on && !running);
        check("hold_fset", 32'(mfs_pkg::FSET_RST), fset_out);
        rd_reg(8'h08);
        check("cycles", 32'h2, v[29:16]);
        $display("test counted run done");
        rec = 0;
        ph = 1;
        n5 = 0;
        wr_reg(8'h24, 32'h5a5);
        wr_reg(8'h44, 32'hc80006);
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h00, 32'h11);
        for (int i = 0; i < 9000 && !(n5 >= 3 && step_out == 3'h3); i++) @(posedge clk);
        check("endless", 1, n5 >= 3);
        sp = 1;
        wr_reg(8'h00, 32'h12);
        for (int i = 0; i < 1000 && out_on; i++) @(posedge clk);
        @(posedge clk);
        check("stopped", 3'h0, step_out);
        wr_reg(8'h00, 32'h11);
        rd_reg(8'h08);
        check("restart", 32'h0, v & 32'h3fff000e);
        $display("test phases and stop done");
        results();
    end
endmodule

// ==== testbench/mfs_stage.sv ====
// Output stage model: a waveform phase that runs free, one degree a cycle.
// Assumes the sequencer's clock and reset.
module mfs_stage (
    input wire logic clk,
    input wire logic resetn,
    output logic [mfs_pkg::AW-1:0] phase_deg
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Phase
    // ----------------------------------------------------------------
    // Free running, so start and stop phase waits take a real time
    always_ff @(posedge clk) begin
        if (!resetn || phase_deg == mfs_pkg::ANGLE_MAX) begin
            phase_deg <= 9'h000;
        end else begin
            phase_deg <= phase_deg + 9'h001;
        end
    end
endmodule
